/* File: logic/frame_report_defines.vh */
`ifndef FRAME_REPORT_DEFINES_VH
`define FRAME_REPORT_DEFINES_VH

// report word layout
`define REPORT_WORD_W      40
`define REPORT_PAYLOAD_LSB 0
`define REPORT_PAYLOAD_MSB 15
`define REPORT_PACKET_LSB  16
`define REPORT_PACKET_MSB  31
`define REPORT_TYPE_LSB    32
`define REPORT_TYPE_MSB    39
`define LEN_W              16
`define TYPE_W             8

// frame type flag positions within the type field
`define TYPE_STACKED_VLAN  0
`define TYPE_VLAN          1
`define TYPE_CONTROL       2
`define TYPE_PAUSE         3
`define TYPE_BROADCAST     4
`define TYPE_MULTICAST     5
`define TYPE_UNICAST       6
`define TYPE_PFC           7

// fault vector layout
`define FAULT_W            7
`define FAULT_UNDERSIZED   0
`define FAULT_OVERSIZED    1
`define FAULT_LENGTH       2
`define FAULT_CRC          3
`define FAULT_UNDERFLOW    4
`define FAULT_CLIENT       5
`define FAULT_PHY          6

// flow control report
`define PFC_QUEUES         8
`define PFC_VECTOR_W       16

// reset values
`define RST_REPORT_WORD    40'h00_0000_0000
`define RST_FAULT          7'h00
`define RST_PFC_VECTOR     16'h0000

`endif

/* File: logic/mac_frame_status_report.v */
`timescale 1ns/1ps
`include "frame_report_defines.vh"

module mac_frame_status_report
(
   input  wire                          i_clk,
   input  wire                          i_rstn,
   // receive side events from the mac core
   input  wire                          i_rx_word_valid,
   input  wire                          i_rx_end_of_frame,
   input  wire                          i_rx_sink_accept,
   input  wire [`LEN_W-1:0]             i_rx_payload_len,
   input  wire [`LEN_W-1:0]             i_rx_packet_len,
   input  wire [`TYPE_W-1:0]            i_rx_frame_type,
   input  wire                          i_rx_undersized,
   input  wire                          i_rx_oversized,
   input  wire                          i_rx_length_error,
   input  wire                          i_rx_crc_error,
   input  wire                          i_rx_phy_error,
   // transmit side events from the mac core
   input  wire                          i_tx_frame_done,
   input  wire [`LEN_W-1:0]             i_tx_payload_len,
   input  wire [`LEN_W-1:0]             i_tx_packet_len,
   input  wire [`TYPE_W-1:0]            i_tx_frame_type,
   input  wire                          i_tx_undersized,
   input  wire                          i_tx_oversized,
   input  wire                          i_tx_length_error,
   input  wire                          i_tx_underflow,
   input  wire                          i_tx_client_error,
   // flow control requests sent, one bit per queue
   input  wire [`PFC_QUEUES-1:0]        i_pfc_xon_sent,
   input  wire [`PFC_QUEUES-1:0]        i_pfc_xoff_sent,
   // outputs
   output reg                           o_rx_last_word_flag,
   output reg                           o_rx_sink_accept,
   output reg                           o_rx_frame_report_strobe,
   output reg  [`REPORT_WORD_W-1:0]     o_rx_frame_report_word,
   output reg  [`FAULT_W-1:0]           o_rx_frame_fault_vector,
   output reg                           o_tx_frame_report_strobe,
   output reg  [`REPORT_WORD_W-1:0]     o_tx_frame_report_word,
   output reg  [`FAULT_W-1:0]           o_tx_frame_fault_vector,
   output reg                           o_tx_flowctl_report_qualifier,
   output reg  [`PFC_VECTOR_W-1:0]      o_tx_flowctl_report_vector
);

   reg                        rst_meta_q;
   reg                        rst_sync_q;
   reg                        rx_report_d;
   reg  [`REPORT_WORD_W-1:0]  rx_word_d;
   reg  [`FAULT_W-1:0]        rx_fault_d;
   reg                        tx_done_q;
   reg                        tx_report_d;
   reg  [`REPORT_WORD_W-1:0]  tx_word_d;
   reg  [`FAULT_W-1:0]        tx_fault_d;
   reg  [`PFC_VECTOR_W-1:0]   pfc_vec_d;
   reg                        pfc_any_d;
   integer                    k;

   function [`REPORT_WORD_W-1:0] pack_report;
      input [`LEN_W-1:0]  payload_len;
      input [`LEN_W-1:0]  packet_len;
      input [`TYPE_W-1:0] frame_type;
      begin
         pack_report = `RST_REPORT_WORD;
         pack_report[`REPORT_PAYLOAD_MSB:`REPORT_PAYLOAD_LSB] = payload_len;
         pack_report[`REPORT_PACKET_MSB:`REPORT_PACKET_LSB] = packet_len;
         pack_report[`REPORT_TYPE_MSB:`REPORT_TYPE_LSB] = frame_type;
      end
   endfunction

   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // only a word both valid and last makes a report; an end
   // marker without valid is ignored, with no visible sign
   always @*
   begin
      rx_report_d = i_rx_word_valid & i_rx_end_of_frame;
      rx_word_d   = o_rx_frame_report_word;
      if (rx_report_d)
      begin
         rx_word_d = pack_report(i_rx_payload_len, i_rx_packet_len,
            i_rx_frame_type);
      end
   end

   // bits 4 and 5 have no receive meaning and stay low
   always @*
   begin
      rx_fault_d = o_rx_frame_fault_vector;
      if (rx_report_d)
      begin
         rx_fault_d[`FAULT_UNDERSIZED] = i_rx_undersized;
         rx_fault_d[`FAULT_OVERSIZED]  = i_rx_oversized;
         rx_fault_d[`FAULT_LENGTH]     = i_rx_length_error;
         rx_fault_d[`FAULT_CRC]        = i_rx_crc_error;
         rx_fault_d[`FAULT_UNDERFLOW]  = 1'b0;
         rx_fault_d[`FAULT_CLIENT]     = 1'b0;
         rx_fault_d[`FAULT_PHY]        = i_rx_phy_error;
      end
   end

   // a rising edge of done makes the report, so a done held high is
   // not reported twice
   always @*
   begin
      tx_report_d = i_tx_frame_done & ~tx_done_q;
      tx_word_d   = o_tx_frame_report_word;
      if (tx_report_d)
      begin
         tx_word_d = pack_report(i_tx_payload_len, i_tx_packet_len,
            i_tx_frame_type);
      end
   end

   // bits 3 and 6 have no transmit meaning and stay low
   always @*
   begin
      tx_fault_d = o_tx_frame_fault_vector;
      if (tx_report_d)
      begin
         tx_fault_d[`FAULT_UNDERSIZED] = i_tx_undersized;
         tx_fault_d[`FAULT_OVERSIZED]  = i_tx_oversized;
         tx_fault_d[`FAULT_LENGTH]     = i_tx_length_error;
         tx_fault_d[`FAULT_CRC]        = 1'b0;
         tx_fault_d[`FAULT_UNDERFLOW]  = i_tx_underflow;
         tx_fault_d[`FAULT_CLIENT]     = i_tx_client_error;
         tx_fault_d[`FAULT_PHY]        = 1'b0;
      end
   end

   // queue k reports xon on bit 2k and xoff on bit 2k+1
   always @*
   begin
      pfc_vec_d = `RST_PFC_VECTOR;
      for (k = 0; k < `PFC_QUEUES; k = k + 1)
      begin
         pfc_vec_d[2*k]   = i_pfc_xon_sent[k];
         pfc_vec_d[2*k+1] = i_pfc_xoff_sent[k];
      end
      pfc_any_d = |pfc_vec_d;
   end

   always @(posedge i_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         o_rx_last_word_flag      <= 1'b0;
         o_rx_sink_accept         <= 1'b0;
         o_rx_frame_report_strobe <= 1'b0;
         o_rx_frame_report_word   <= `RST_REPORT_WORD;
         o_rx_frame_fault_vector  <= `RST_FAULT;
      end
      else
      begin
         // accept low marks overflow, where the report is not to be trusted
         o_rx_sink_accept         <= i_rx_sink_accept;
         // last word and its report leave through the same flop stage
         o_rx_last_word_flag      <= rx_report_d;
         o_rx_frame_report_strobe <= rx_report_d;
         // undefined under overflow or stripping, passed on all the same
         o_rx_frame_report_word   <= rx_word_d;
         o_rx_frame_fault_vector  <= rx_fault_d;
      end
   end

   always @(posedge i_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         tx_done_q                <= 1'b0;
         o_tx_frame_report_strobe <= 1'b0;
         o_tx_frame_report_word   <= `RST_REPORT_WORD;
         o_tx_frame_fault_vector  <= `RST_FAULT;
      end
      else
      begin
         tx_done_q                <= i_tx_frame_done;
         o_tx_frame_report_strobe <= tx_report_d;
         // undefined under overflow or insertion, passed on all the same
         o_tx_frame_report_word   <= tx_word_d;
         o_tx_frame_fault_vector  <= tx_fault_d;
      end
   end

   always @(posedge i_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         o_tx_flowctl_report_qualifier <= 1'b0;
         o_tx_flowctl_report_vector    <= `RST_PFC_VECTOR;
      end
      else
      begin
         o_tx_flowctl_report_qualifier <= pfc_any_d;
         o_tx_flowctl_report_vector    <= pfc_vec_d;
      end
   end

endmodule // mac_frame_status_report

/* File: test/frame_report_monitor.sv */
`timescale 1ns/1ps
module frame_report_monitor
(
   input wire        i_clk,
   input wire        i_rstn,
   input wire        i_rx_word_valid,
   input wire        i_rx_end_of_frame,
   input wire        i_rx_crc_error,
   input wire        i_tx_frame_done,
   input wire [15:0] i_rx_payload_len,
   input wire [15:0] i_tx_payload_len,
   input wire [7:0]  i_pfc_xon_sent,
   input wire [7:0]  i_pfc_xoff_sent,
   input wire        o_rx_frame_report_strobe,
   input wire        o_rx_last_word_flag,
   input wire        o_tx_frame_report_strobe,
   input wire        o_tx_flowctl_report_qualifier,
   input wire [39:0] o_rx_frame_report_word,
   input wire [39:0] o_tx_frame_report_word,
   input wire [6:0]  o_rx_frame_fault_vector,
   input wire [6:0]  o_tx_frame_fault_vector,
   input wire [15:0] o_tx_flowctl_report_vector
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   sequence rx_end;
      i_rx_word_valid && i_rx_end_of_frame;
   endsequence
   sequence tx_rise;
      !i_tx_frame_done ##1 i_tx_frame_done;
   endsequence
   AST_RX_PULSE: assert property (rx_end |=> o_rx_frame_report_strobe
      && o_rx_last_word_flag) else $error("rx report missing");
   AST_RX_CAUSE: assert property (o_rx_frame_report_strobe |->
      $past(i_rx_word_valid && i_rx_end_of_frame)) else $error("rx extra");
   AST_RX_WORD: assert property (o_rx_frame_report_strobe |->
      o_rx_frame_report_word[15:0] == $past(i_rx_payload_len) &&
      o_rx_frame_fault_vector[3] == $past(i_rx_crc_error))
      else $error("rx word wrong");
   AST_RX_SPARE: assert property (o_rx_frame_report_strobe |->
      o_rx_frame_fault_vector[5:4] == 2'b00) else $error("rx spare set");
   AST_TX_ONCE: assert property (tx_rise |=> o_tx_frame_report_strobe
      ##1 !o_tx_frame_report_strobe) else $error("tx report wrong");
   AST_TX_WORD: assert property (o_tx_frame_report_strobe |->
      o_tx_frame_report_word[15:0] == $past(i_tx_payload_len) &&
      !o_tx_frame_fault_vector[3] && !o_tx_frame_fault_vector[6])
      else $error("tx word wrong");
   AST_PFC_MAP: assert property (o_tx_flowctl_report_vector[5:4] ==
      {$past(i_pfc_xoff_sent[2]), $past(i_pfc_xon_sent[2])})
      else $error("flow map wrong");
   AST_PFC_QUAL: assert property (o_tx_flowctl_report_qualifier ==
      (o_tx_flowctl_report_vector != 16'h0000)) else $error("qual wrong");
endmodule // frame_report_monitor
bind mac_frame_status_report frame_report_monitor u_mon (.*);

/* File: test/frame_client_model.sv */
`timescale 1ns/1ps
module frame_client_model
(
   input  wire       i_clk,
   input  wire       i_rstn,
   input  wire       i_rx_strobe,
   input  wire       i_rx_accept,
   input  wire       i_tx_strobe,
   output reg  [7:0] o_rx_kept,
   output reg  [7:0] o_tx_kept
);
   // records during overflow are junk, so they are left out of the rx counter
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         {o_rx_kept, o_tx_kept} <= 16'h0000;
      else
         {o_rx_kept, o_tx_kept} <= {o_rx_kept + (i_rx_strobe && i_rx_accept),
            o_tx_kept + i_tx_strobe};
   end
endmodule // frame_client_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected t=%0t %h %h", $time, a, b); end end
module tb_top;
   reg i_clk = 0, i_rstn = 0, i_rx_word_valid = 0, i_rx_end_of_frame = 0;
   reg i_rx_sink_accept = 1, i_tx_frame_done = 0;
   reg i_rx_undersized = 0, i_rx_oversized = 0, i_rx_length_error = 0;
   reg i_rx_crc_error = 0, i_rx_phy_error = 0, i_tx_undersized = 0;
   reg i_tx_oversized = 0, i_tx_length_error = 0, i_tx_underflow = 0;
   reg i_tx_client_error = 0;
   reg [15:0] i_rx_payload_len = 0, i_rx_packet_len = 0;
   reg [15:0] i_tx_payload_len = 0, i_tx_packet_len = 0;
   reg [7:0]  i_rx_frame_type = 0, i_tx_frame_type = 0;
   reg [7:0]  i_pfc_xon_sent = 0, i_pfc_xoff_sent = 0;
   wire o_rx_last_word_flag, o_rx_sink_accept, o_rx_frame_report_strobe;
   wire o_tx_frame_report_strobe, o_tx_flowctl_report_qualifier;
   wire [39:0] o_rx_frame_report_word, o_tx_frame_report_word;
   wire [6:0]  o_rx_frame_fault_vector, o_tx_frame_fault_vector;
   wire [15:0] o_tx_flowctl_report_vector;
   wire [7:0]  rx_kept, tx_kept;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   mac_frame_status_report u_dut (.*);
   frame_client_model u_client (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_rx_strobe(o_rx_frame_report_strobe), .i_rx_accept(o_rx_sink_accept),
      .i_tx_strobe(o_tx_frame_report_strobe), .o_rx_kept(rx_kept),
      .o_tx_kept(tx_kept));
   initial forever #12.5 i_clk = ~i_clk;
   task close_out;
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // back-to-back frames; last pass sends an end flag without valid
   task t_rx;
      reg [7:0] k, j;
      reg [4:0] f;
      reg [39:0] w;
      for (k = 0; k <= 8; k++)
      begin
         @(negedge i_clk);
         j = k - 8'h01;
         f = j[4:0] * 5'h03 + 5'h01;
         if (k > 0)
         begin
            w = {8'h01 << j[2:0], 8'h02, j, 8'h01, j};
            `CHK(o_rx_last_word_flag, 1'b1)
            `CHK(o_rx_frame_report_strobe, 1'b1)
            `CHK(o_rx_frame_report_word, w)
            `CHK(o_rx_frame_fault_vector, {f[4], 2'b00, f[3:0]})
         end
         f = k[4:0] * 5'h03 + 5'h01;
         {i_rx_word_valid, i_rx_end_of_frame, i_rx_sink_accept} =
            {k < 8, 1'b1, k < 6};
         {i_rx_phy_error, i_rx_crc_error, i_rx_length_error, i_rx_oversized,
            i_rx_undersized} = f;
         {i_rx_frame_type, i_rx_packet_len, i_rx_payload_len} =
            {8'h01 << k[2:0], 8'h02, k, 8'h01, k};
      end
      @(negedge i_clk);
      `CHK(o_rx_frame_report_strobe, 1'b0)
      i_rx_end_of_frame = 0;
      repeat (2) @(negedge i_clk);
      `CHK(rx_kept, 8'h06)
   endtask
   task t_tx;
      reg [2:0] k;
      reg [4:0] f;
      reg [39:0] w;
      for (k = 0; k < 5; k++)
      begin
         @(negedge i_clk);
         f = 5'h01 << k;
         i_tx_frame_done = 1;
         {i_tx_client_error, i_tx_underflow, i_tx_length_error, i_tx_oversized,
            i_tx_undersized} = f;
         w = {8'h80 >> k, 8'h03, 5'h00, k, 8'h04, 5'h00, k};
         {i_tx_frame_type, i_tx_packet_len, i_tx_payload_len} = w;
         @(negedge i_clk);
         `CHK(o_tx_frame_report_strobe, 1'b1)
         `CHK(o_tx_frame_report_word, w)
         `CHK(o_tx_frame_fault_vector, {1'b0, f[4:3], 1'b0, f[2:0]})
         @(negedge i_clk);
         `CHK(o_tx_frame_report_strobe, 1'b0)
         i_tx_frame_done = 0;
      end
      repeat (2) @(negedge i_clk);
      `CHK(tx_kept, 8'h05)
   endtask
   task t_pfc;
      reg [3:0] k;
      for (k = 0; k < 9; k++)
      begin
         @(negedge i_clk);
         if (k > 0)
         begin
            `CHK(o_tx_flowctl_report_vector, (16'h0001 << (2 * k - 2)) |
               (16'h0002 << (2 * (k % 8))))
            `CHK(o_tx_flowctl_report_qualifier, 1'b1)
         end
         {i_pfc_xon_sent, i_pfc_xoff_sent} = (k < 8) ?
            {8'h01 << k[2:0], 8'h01 << (k[2:0] + 3'h1)} : 16'h0000;
      end
      @(negedge i_clk);
      `CHK(o_tx_flowctl_report_qualifier, 1'b0)
   endtask
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_mismatch++;
         close_out;
      end
   end
   initial
   begin
      repeat (12) @(negedge i_clk);
      i_rstn = 1;
      repeat (3) @(negedge i_clk);
      `CHK(o_tx_frame_report_strobe, 1'b0)
      `CHK(o_tx_frame_report_word, 40'h0000000000)
      t_rx;
      t_tx;
      t_pfc;
      close_out;
   end
endmodule // tb_top
